// ==== include/adcov_pkg.sv ====
// Register map, field positions and widths of the override control bank
package adcov_pkg;
  localparam int ADCOV_ADDR_W = 12;
  localparam int ADCOV_IDX_LSB = 2;
  // Register indices, as wide as the decoded index; byte address is four times the index
  localparam logic [ADCOV_ADDR_W-ADCOV_IDX_LSB-1:0] ADCOV_IDX_FMT_IL = 10'h04B;
  localparam logic [ADCOV_ADDR_W-ADCOV_IDX_LSB-1:0] ADCOV_IDX_DEC_FRZ = 10'h04D;
  localparam logic [ADCOV_ADDR_W-ADCOV_IDX_LSB-1:0] ADCOV_IDX_ZONE_BOOST = 10'h04E;
  localparam logic [ADCOV_ADDR_W-ADCOV_IDX_LSB-1:0] ADCOV_IDX_REORDER_GAIN = 10'h052;
  localparam logic [ADCOV_ADDR_W-ADCOV_IDX_LSB-1:0] ADCOV_IDX_STATUS = 10'h060;
  localparam int ADCOV_REG_W = 8;
  localparam logic [7:0] ADCOV_RESET = 8'h00;
  // Field positions
  localparam int ADCOV_BIT_FORMAT_OVR = 5;
  localparam int ADCOV_BIT_IL_MODE_OVR = 2;
  localparam int ADCOV_BIT_DEC_OVR = 3;
  localparam int ADCOV_BIT_FREEZE_OVR = 0;
  localparam int ADCOV_BIT_ZONE_OVR = 7;
  localparam int ADCOV_BIT_BOOST = 5;
  localparam int ADCOV_BIT_REORDER = 7;
  localparam int ADCOV_BIT_GAIN_EN = 0;
  localparam int ADCOV_BIT_ST_FROZEN = 0;
  localparam int ADCOV_BIT_ST_ZONE_OK = 1;
  // Field widths and zone codes
  localparam int ADCOV_DEC_W = 4;
  localparam int ADCOV_ZONE_W = 3;
  localparam int ADCOV_GAIN_W = 7;
  localparam logic [2:0] ADCOV_ZONE_FIRST = 3'h0;
  localparam logic [2:0] ADCOV_ZONE_SECOND = 3'h1;
  localparam logic [2:0] ADCOV_ZONE_THIRD = 3'h2;
endpackage : adcov_pkg

// ==== rtl/adcov_regs.sv ====
// Override control register bank with APB slave and gated control outputs
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module adcov_regs
  import adcov_pkg::*;
#(
  parameter int IL_MODE_W = 2,
  parameter logic [IL_MODE_W-1:0] IL_MODE_DEFAULT = '0
)
(
  input wire logic i_clk,
  input wire logic i_srst,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADCOV_ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Target field values held elsewhere
  input wire logic i_format_select,
  input wire logic [IL_MODE_W-1:0] i_interleave_corrector_mode_field,
  input wire logic [ADCOV_DEC_W-1:0] i_decimation_filter_setting,
  input wire logic i_interleave_corrector_hold,
  input wire logic [ADCOV_ZONE_W-1:0] i_zone_field,
  input wire logic [ADCOV_GAIN_W-1:0] i_gain_value,
  // Effective controls
  output logic o_offset_binary,
  output logic [IL_MODE_W-1:0] o_interleave_mode,
  output logic o_decimation_apply,
  output logic [ADCOV_DEC_W-1:0] o_decimation_setting,
  output logic o_interleave_frozen,
  output logic o_zone_enable,
  output logic [1:0] o_zone_index,
  output logic o_interleave_boost,
  output logic o_bus_reorder_first,
  output logic o_gain_apply,
  output logic [ADCOV_GAIN_W-1:0] o_gain
);

  // Stored bits; reserved positions are not kept at all
  logic format_override, interleave_mode_override, decimation_mode_override;
  logic freeze_control_override, zone_override, interleave_boost;
  logic bus_reorder_first, gain_apply_enable;
  logic [31:0] prdata;
  logic next_format_override, next_interleave_mode_override, next_decimation_mode_override;
  logic next_freeze_control_override, next_zone_override, next_interleave_boost;
  logic next_bus_reorder_first, next_gain_apply_enable;
  logic [31:0] next_prdata;

  // Effective control state
  logic offset_binary, dec_apply, frozen, zone_enable, gain_apply;
  logic [IL_MODE_W-1:0] il_mode;
  logic [ADCOV_DEC_W-1:0] dec_setting;
  logic [1:0] zone_index;
  logic [ADCOV_GAIN_W-1:0] gain;
  logic next_offset_binary, next_dec_apply, next_frozen, next_zone_enable, next_gain_apply;
  logic [IL_MODE_W-1:0] next_il_mode;
  logic [ADCOV_DEC_W-1:0] next_dec_setting;
  logic [1:0] next_zone_index;
  logic [ADCOV_GAIN_W-1:0] next_gain;

  logic [ADCOV_IDX_LSB-1:0] addr_low;
  logic [ADCOV_ADDR_W-ADCOV_IDX_LSB-1:0] addr_idx;
  logic mapped, setup, access, wr_ok;

  // Register index of a mapped address, only aligned words decode
  function automatic logic adcov_is_mapped(input logic [ADCOV_ADDR_W-ADCOV_IDX_LSB-1:0] idx,
                                           input logic [ADCOV_IDX_LSB-1:0] low);
    logic hit;
    hit = (idx == ADCOV_IDX_FMT_IL) || (idx == ADCOV_IDX_DEC_FRZ) ||
          (idx == ADCOV_IDX_ZONE_BOOST) || (idx == ADCOV_IDX_REORDER_GAIN) ||
          (idx == ADCOV_IDX_STATUS);
    return hit && (low == '0);
  endfunction : adcov_is_mapped

  // Bus decode; zero wait states, so pready is a constant high
  assign addr_low = i_paddr[ADCOV_IDX_LSB-1:0];
  assign addr_idx = i_paddr[ADCOV_ADDR_W-1:ADCOV_IDX_LSB];
  assign mapped = adcov_is_mapped(addr_idx, addr_low);
  assign setup = i_psel && !i_penable;
  assign access = i_psel && i_penable;
  assign wr_ok = access && i_pwrite && mapped && i_pstrb[0];
  assign o_pready = 1'b1;
  assign o_pslverr = access && !mapped;

  // Register writes in the access cycle, read capture in the setup cycle
  always_comb
  begin
    next_format_override = format_override;
    next_interleave_mode_override = interleave_mode_override;
    next_decimation_mode_override = decimation_mode_override;
    next_freeze_control_override = freeze_control_override;
    next_zone_override = zone_override;
    next_interleave_boost = interleave_boost;
    next_bus_reorder_first = bus_reorder_first;
    next_gain_apply_enable = gain_apply_enable;
    next_prdata = prdata;
    if (wr_ok)
    begin
      case (addr_idx)
        ADCOV_IDX_FMT_IL:
        begin
          next_format_override = i_pwdata[ADCOV_BIT_FORMAT_OVR];
          next_interleave_mode_override = i_pwdata[ADCOV_BIT_IL_MODE_OVR];
        end
        ADCOV_IDX_DEC_FRZ:
        begin
          next_decimation_mode_override = i_pwdata[ADCOV_BIT_DEC_OVR];
          next_freeze_control_override = i_pwdata[ADCOV_BIT_FREEZE_OVR];
        end
        ADCOV_IDX_ZONE_BOOST:
        begin
          next_zone_override = i_pwdata[ADCOV_BIT_ZONE_OVR];
          next_interleave_boost = i_pwdata[ADCOV_BIT_BOOST];
        end
        ADCOV_IDX_REORDER_GAIN:
        begin
          next_bus_reorder_first = i_pwdata[ADCOV_BIT_REORDER];
          next_gain_apply_enable = i_pwdata[ADCOV_BIT_GAIN_EN];
        end
        default: next_prdata = prdata; // Status is read only
      endcase
    end
    // Read word captured early so prdata comes from a flop
    if (setup)
    begin
      next_prdata = '0;
      case (addr_idx)
        ADCOV_IDX_FMT_IL:
        begin
          next_prdata[ADCOV_BIT_FORMAT_OVR] = format_override;
          next_prdata[ADCOV_BIT_IL_MODE_OVR] = interleave_mode_override;
        end
        ADCOV_IDX_DEC_FRZ:
        begin
          next_prdata[ADCOV_BIT_DEC_OVR] = decimation_mode_override;
          next_prdata[ADCOV_BIT_FREEZE_OVR] = freeze_control_override;
        end
        ADCOV_IDX_ZONE_BOOST:
        begin
          next_prdata[ADCOV_BIT_ZONE_OVR] = zone_override;
          next_prdata[ADCOV_BIT_BOOST] = interleave_boost;
        end
        ADCOV_IDX_REORDER_GAIN:
        begin
          next_prdata[ADCOV_BIT_REORDER] = bus_reorder_first;
          next_prdata[ADCOV_BIT_GAIN_EN] = gain_apply_enable;
        end
        ADCOV_IDX_STATUS:
        begin
          next_prdata[ADCOV_BIT_ST_FROZEN] = frozen;
          next_prdata[ADCOV_BIT_ST_ZONE_OK] = zone_enable;
        end
        default: next_prdata = '0;
      endcase
      if (addr_low != '0)
      begin
        next_prdata = '0;
      end
    end
  end

  // Register bank flops
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      format_override <= ADCOV_RESET[ADCOV_BIT_FORMAT_OVR];
      interleave_mode_override <= ADCOV_RESET[ADCOV_BIT_IL_MODE_OVR];
      decimation_mode_override <= ADCOV_RESET[ADCOV_BIT_DEC_OVR];
      freeze_control_override <= ADCOV_RESET[ADCOV_BIT_FREEZE_OVR];
      zone_override <= ADCOV_RESET[ADCOV_BIT_ZONE_OVR];
      interleave_boost <= ADCOV_RESET[ADCOV_BIT_BOOST];
      bus_reorder_first <= ADCOV_RESET[ADCOV_BIT_REORDER];
      gain_apply_enable <= ADCOV_RESET[ADCOV_BIT_GAIN_EN];
      prdata <= '0;
    end
    else
    begin
      format_override <= next_format_override;
      interleave_mode_override <= next_interleave_mode_override;
      decimation_mode_override <= next_decimation_mode_override;
      freeze_control_override <= next_freeze_control_override;
      zone_override <= next_zone_override;
      interleave_boost <= next_interleave_boost;
      bus_reorder_first <= next_bus_reorder_first;
      gain_apply_enable <= next_gain_apply_enable;
      prdata <= next_prdata;
    end
  end

  // Effective controls, one cycle behind the stored bits and inputs
  always_comb
  begin
    next_offset_binary = format_override && i_format_select;
    next_il_mode = interleave_mode_override ? i_interleave_corrector_mode_field : IL_MODE_DEFAULT;
    next_dec_apply = decimation_mode_override;
    next_dec_setting = decimation_mode_override ? i_decimation_filter_setting : '0;
    next_frozen = frozen;
    if (freeze_control_override)
    begin
      next_frozen = i_interleave_corrector_hold;
    end
    next_zone_enable = 1'b0;
    next_zone_index = 2'h0;
    if (zone_override)
    begin
      case (i_zone_field)
        ADCOV_ZONE_FIRST, ADCOV_ZONE_SECOND, ADCOV_ZONE_THIRD:
        begin
          next_zone_enable = 1'b1;
          next_zone_index = i_zone_field[1:0]; // Used codes equal the zone number
        end
        default: next_zone_enable = 1'b0;
      endcase
    end
    next_gain_apply = gain_apply_enable;
    next_gain = gain_apply_enable ? i_gain_value : '0;
  end

  // Effective control flops; corrector starts unfrozen
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      offset_binary <= 1'b0;
      il_mode <= IL_MODE_DEFAULT;
      dec_apply <= 1'b0;
      dec_setting <= '0;
      frozen <= 1'b0;
      zone_enable <= 1'b0;
      zone_index <= 2'h0;
      gain_apply <= 1'b0;
      gain <= '0;
    end
    else
    begin
      offset_binary <= next_offset_binary;
      il_mode <= next_il_mode;
      dec_apply <= next_dec_apply;
      dec_setting <= next_dec_setting;
      frozen <= next_frozen;
      zone_enable <= next_zone_enable;
      zone_index <= next_zone_index;
      gain_apply <= next_gain_apply;
      gain <= next_gain;
    end
  end

  // Outputs; boost band is the corrector's concern, not checked here
  assign o_prdata = prdata;
  assign o_offset_binary = offset_binary;
  assign o_interleave_mode = il_mode;
  assign o_decimation_apply = dec_apply;
  assign o_decimation_setting = dec_setting;
  assign o_interleave_frozen = frozen;
  assign o_zone_enable = zone_enable;
  assign o_zone_index = zone_index;
  assign o_interleave_boost = interleave_boost;
  assign o_bus_reorder_first = bus_reorder_first;
  assign o_gain_apply = gain_apply;
  assign o_gain = gain;

endmodule : adcov_regs
`default_nettype wire

// ==== testbench/adcov_apb_host.sv ====
// APB host model driving the bank's register port
`timescale 1ns/1ps
`default_nettype none
module adcov_apb_host
  import adcov_pkg::*;
(
  input wire logic i_clk,
  input wire logic [31:0] i_prdata,
  input wire logic i_pready,
  input wire logic i_pslverr,
  output var logic o_psel,
  output var logic o_penable,
  output var logic o_pwrite,
  output var logic [ADCOV_ADDR_W-1:0] o_paddr,
  output var logic [31:0] o_pwdata,
  output var logic [3:0] o_pstrb
);
  // Idle bus from time zero
  initial
  begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = '0;
    o_pwdata = '0;
    o_pstrb = '0;
  end
  // One transfer, held until pready is sampled high
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] rd, output logic e);
    @(posedge i_clk);
    o_psel <= 1'b1;
    o_pwrite <= w;
    o_paddr <= a;
    o_pwdata <= d;
    o_pstrb <= s;
    @(posedge i_clk);
    o_penable <= 1'b1;
    @(posedge i_clk);
    while (i_pready !== 1'b1)
      @(posedge i_clk);
    rd = i_prdata;
    e = i_pslverr;
    o_psel <= 1'b0;
    o_penable <= 1'b0;
    // Released address and data lines flip so a stale value never passes
    o_paddr <= ~a;
    o_pwdata <= ~d;
  endtask : xfer
endmodule : adcov_apb_host
`default_nettype wire

// ==== testbench/adcov_regs_properties.sv ====
// Checker for the override control bank ports
`timescale 1ns/1ps
`default_nettype none
module adcov_regs_properties
  import adcov_pkg::*;
#(
  parameter int IL_MODE_W = 2,
  parameter logic [IL_MODE_W-1:0] IL_MODE_DEFAULT = '0
)
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADCOV_ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic i_format_select,
  input wire logic o_offset_binary,
  input wire logic [IL_MODE_W-1:0] i_interleave_corrector_mode_field,
  input wire logic [IL_MODE_W-1:0] o_interleave_mode,
  input wire logic [ADCOV_DEC_W-1:0] i_decimation_filter_setting,
  input wire logic o_decimation_apply,
  input wire logic [ADCOV_DEC_W-1:0] o_decimation_setting,
  input wire logic i_interleave_corrector_hold,
  input wire logic o_interleave_frozen,
  input wire logic [ADCOV_ZONE_W-1:0] i_zone_field,
  input wire logic o_zone_enable,
  input wire logic [1:0] o_zone_index,
  input wire logic [ADCOV_GAIN_W-1:0] i_gain_value,
  input wire logic o_gain_apply,
  input wire logic [ADCOV_GAIN_W-1:0] o_gain
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);
  // Gain enable written, then live two edges later
  sequence s_gain_on_write;
    i_psel && i_penable && i_pwrite && i_pstrb[0] && i_paddr == 12'h148 && i_pwdata[0];
  endsequence
  sequence s_gain_live;
    ##2 o_gain_apply;
  endsequence
  a_gain_write_lat: assert property (s_gain_on_write |-> s_gain_live)
    else $error("gain enable late");
  a_gain_gate: assert property (o_gain == (o_gain_apply ? $past(i_gain_value) : 7'h00))
    else $error("gain not gated");
  a_offset_cause: assert property (o_offset_binary |-> $past(i_format_select))
    else $error("offset binary without select");
  a_mode_gate: assert property (o_interleave_mode != IL_MODE_DEFAULT
    |-> o_interleave_mode == $past(i_interleave_corrector_mode_field))
    else $error("engine mode not from field");
  a_dec_gate: assert property (o_decimation_setting ==
    (o_decimation_apply ? $past(i_decimation_filter_setting) : 4'h0))
    else $error("decimation not gated");
  a_frozen_source: assert property ($changed(o_interleave_frozen)
    |-> o_interleave_frozen == $past(i_interleave_corrector_hold))
    else $error("freeze changed against hold field");
  a_zone_decode: assert property (o_zone_enable
    |-> {1'b0, o_zone_index} == $past(i_zone_field) && o_zone_index != 2'h3)
    else $error("zone decode wrong");
  a_bus_answer: assert property (i_psel && i_penable |-> o_pready &&
    o_pslverr == !(i_paddr inside {12'h12C, 12'h134, 12'h138, 12'h148, 12'h180}))
    else $error("bus answer wrong");
endmodule : adcov_regs_properties
bind adcov_regs adcov_regs_properties
  #(.IL_MODE_W(IL_MODE_W), .IL_MODE_DEFAULT(IL_MODE_DEFAULT)) adcov_regs_properties_inst (.*);
`default_nettype wire

// ==== testbench/tb_adc_digital_override_controls.sv ====
// Self-checking bench for the override control bank
`timescale 1ns/1ps
`default_nettype none
module tb_adc_digital_override_controls;
  import adcov_pkg::*;
  // Row: address, write data, readback, field inputs, gated outputs
  typedef struct packed {
    logic [11:0] a;
    logic [7:0] wd;
    logic [7:0] rd;
    logic [17:0] fi;
    logic [21:0] fo;
  } adcov_row_t;
  logic i_clk;
  logic i_srst;
  logic [17:0] fin;
  logic [31:0] rdat;
  logic err;
  wire logic psel, penable, pwrite, pready, pslverr;
  wire logic [11:0] paddr;
  wire logic [31:0] pwdata, prdata;
  wire logic [3:0] pstrb;
  wire logic [21:0] fout;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  // Reserved bits written as ones are dropped; reorder set for down-converter mode
  adcov_row_t rows [10] = '{
    '{12'h12C, 8'h20, 8'h20, 18'h3AC55, 22'h200000},
    '{12'h12C, 8'hFF, 8'h24, 18'h12C55, 22'h100000},
    '{12'h134, 8'h08, 8'h08, 18'h2DC55, 22'h2EC000},
    '{12'h134, 8'hFF, 8'h09, 18'h29C55, 22'h2CE000},
    '{12'h134, 8'h08, 8'h08, 18'h2F855, 22'h2FE000},
    '{12'h138, 8'hFF, 8'hA0, 18'h2F955, 22'h2FFA00},
    '{12'h138, 8'h80, 8'h80, 18'h2FAD5, 22'h2FE000},
    '{12'h148, 8'hFF, 8'h81, 18'h2F8FF, 22'h2FF5FF},
    '{12'h148, 8'h00, 8'h00, 18'h2F812, 22'h2FF000},
    '{12'h134, 8'h01, 8'h01, 18'h2FC12, 22'h283000}};
  adcov_regs #(.IL_MODE_W(2), .IL_MODE_DEFAULT(2'h0)) adcov_regs_inst (
    .i_clk(i_clk), .i_srst(i_srst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_format_select(fin[17]),
    .i_interleave_corrector_mode_field(fin[16:15]), .i_decimation_filter_setting(fin[14:11]),
    .i_interleave_corrector_hold(fin[10]), .i_zone_field(fin[9:7]), .i_gain_value(fin[6:0]),
    .o_offset_binary(fout[21]), .o_interleave_mode(fout[20:19]), .o_decimation_apply(fout[18]),
    .o_decimation_setting(fout[17:14]), .o_interleave_frozen(fout[13]),
    .o_zone_enable(fout[12]), .o_zone_index(fout[11:10]), .o_interleave_boost(fout[9]),
    .o_bus_reorder_first(fout[8]), .o_gain_apply(fout[7]), .o_gain(fout[6:0]));
  adcov_apb_host adcov_apb_host_inst (.i_clk(i_clk), .i_prdata(prdata), .i_pready(pready),
    .i_pslverr(pslverr), .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite),
    .o_paddr(paddr), .o_pwdata(pwdata), .o_pstrb(pstrb));
  task automatic chk_bus(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: bus %h, want %h", $time, got, exp);
    end
  endtask : chk_bus
  task automatic chk_out(input logic [21:0] got, input logic [21:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: outputs %h, want %h", $time, got, exp);
    end
  endtask : chk_out
  task automatic rw(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [3:0] s);
    adcov_apb_host_inst.xfer(w, a, {24'h0, d}, s, rdat, err);
  endtask : rw
  // The four control registers and gated outputs all read zero after reset
  task automatic check_zero();
    logic [11:0] addrs [4] = '{12'h12C, 12'h134, 12'h138, 12'h148};
    @(posedge i_clk);
    #1;
    chk_out(fout, 22'h0);
    foreach (addrs[k])
    begin
      rw(1'b0, addrs[k], 8'h00, 4'hF);
      chk_bus(rdat, 32'h0);
    end
  endtask : check_zero
  task automatic test_done();
    if (error_cnt == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done
  // 40 MHz clock
  initial
  begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  // Cut a hang short well past the expected 132 or so cycles
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      error_cnt++;
      test_done();
    end
  end
  // Table rows, then bus refusals, status and a second reset
  initial
  begin
    i_srst = 1'b1;
    fin = '0;
    repeat (3) @(posedge i_clk);
    i_srst <= 1'b0;
    check_zero();
    foreach (rows[k])
    begin
      // Fields change after the write lands, so a still-set override from an earlier row sees them too
      rw(1'b1, rows[k].a, rows[k].wd, 4'hF);
      fin <= rows[k].fi;
      repeat (2) @(posedge i_clk);
      #1;
      chk_out(fout, rows[k].fo);
      rw(1'b0, rows[k].a, 8'h00, 4'hF);
      chk_bus(rdat, {24'h0, rows[k].rd});
    end
    rw(1'b0, 12'h100, 8'h00, 4'hF);
    chk_bus({rdat[31:1], err}, 32'h1);
    rw(1'b1, 12'h12D, 8'h00, 4'hF);
    chk_bus({31'h0, err}, 32'h1);
    rw(1'b1, 12'h12C, 8'h00, 4'hE);
    rw(1'b0, 12'h12C, 8'h00, 4'hF);
    chk_bus(rdat, 32'h24);
    rw(1'b1, 12'h180, 8'h00, 4'hF);
    rw(1'b0, 12'h180, 8'h00, 4'hF);
    chk_bus(rdat, 32'h3);
    // Freeze override still set: a cleared hold field unfreezes the corrector
    fin <= 18'h2F812;
    repeat (2) @(posedge i_clk);
    #1;
    chk_out(fout, 22'h281000);
    i_srst <= 1'b1;
    repeat (3) @(posedge i_clk);
    i_srst <= 1'b0;
    check_zero();
    test_done();
  end
endmodule : tb_adc_digital_override_controls
`default_nettype wire
